/* epc_pkg.sv */
// epc_pkg: constants and carrier types for the exception priority controller.
// assumes a single 50 MHz clock domain and the plain register port of the top module.
`default_nettype none

package epc_pkg;

	localparam int unsigned CLK_MHZ      = 50;
	localparam int unsigned NUM_LINES    = 30;
	localparam int unsigned NUM_EXC      = 16 + NUM_LINES;
	localparam int unsigned PRIO_W       = 3;
	localparam int unsigned LVL_W        = 5;
	localparam int unsigned POS_W        = 6;
	localparam int unsigned PRIO_RESET   = 0;

	// active levels: fixed ones below all settable ones, except base above them
	localparam logic [LVL_W-1:0] LVL_RESET = 5'h00;
	localparam logic [LVL_W-1:0] LVL_NMI   = 5'h01;
	localparam logic [LVL_W-1:0] LVL_HARD  = 5'h02;
	localparam logic [LVL_W-1:0] LVL_PROG0 = 5'h03;
	localparam logic [LVL_W-1:0] LVL_BASE  = 5'h1F;

	localparam logic [POS_W-1:0] POS_NONE   = 6'h00;
	localparam logic [POS_W-1:0] POS_RESET  = 6'h01;
	localparam logic [POS_W-1:0] POS_NMI    = 6'h02;
	localparam logic [POS_W-1:0] POS_HARD   = 6'h03;
	localparam logic [POS_W-1:0] POS_MEM    = 6'h04;
	localparam logic [POS_W-1:0] POS_BUS    = 6'h05;
	localparam logic [POS_W-1:0] POS_USAGE  = 6'h06;
	localparam logic [POS_W-1:0] POS_SUPV   = 6'h0B;
	localparam logic [POS_W-1:0] POS_DEBUG  = 6'h0C;
	localparam logic [POS_W-1:0] POS_PEND   = 6'h0E;
	localparam logic [POS_W-1:0] POS_TICK   = 6'h0F;
	localparam logic [POS_W-1:0] POS_LINE0  = 6'h10;

	// peripheral line map
	localparam int unsigned LINE_PORT_A  = 0;
	localparam int unsigned LINE_PORT_E  = 4;
	localparam int unsigned LINE_SERIAL0 = 5;
	localparam int unsigned LINE_SERIAL1 = 6;
	localparam int unsigned LINE_SYNC0   = 7;
	localparam int unsigned LINE_TWI0    = 8;
	localparam int unsigned LINE_WDOG    = 18;
	localparam int unsigned LINE_TIMER0A = 19;
	localparam int unsigned LINE_COMP0   = 25;
	localparam int unsigned LINE_SYSCTL  = 28;
	localparam int unsigned LINE_FLASH   = 29;
	localparam logic [NUM_LINES-1:0] LINE_IMPL = 30'h3FFC01FF;

	// register offsets (byte addresses)
	localparam logic [7:0] REG_ENABLE  = 8'h00;
	localparam logic [7:0] REG_PENDING = 8'h04;
	localparam logic [7:0] REG_CTRL    = 8'h08;
	localparam logic [7:0] REG_GROUP   = 8'h0C;
	localparam logic [7:0] REG_STATUS  = 8'h10;
	localparam logic [7:0] REG_SYSPRI  = 8'h14;
	localparam logic [7:0] REG_PRI0    = 8'h20;
	// ctrl bits: 0, 1 and 4 write one to act; 2 and 3 hold the written value
	localparam int unsigned CTRL_NMI_SET  = 0;
	localparam int unsigned CTRL_PEND_SET = 1;
	localparam int unsigned CTRL_BUS_EN   = 2;
	localparam int unsigned CTRL_DBG_EN   = 3;
	localparam int unsigned CTRL_PEND_CLR = 4;

	typedef enum logic [1:0] {
		EPC_IDLE  = 2'b00,
		EPC_STACK = 2'b01,
		EPC_RUN   = 2'b11,
		EPC_CHAIN = 2'b10
	} epc_state_t;

	// core-side fault and event strobes
	typedef struct packed {
		logic mem_fault;
		logic bus_fault;
		logic usage_fault;
		logic supv_call;
		logic debug_req;
		logic tick;
	} epc_core_ev_t;

	typedef struct packed {
		logic             valid;
		logic [POS_W-1:0] pos;
		logic [LVL_W-1:0] level;
	} epc_pick_t;

endpackage

`default_nettype wire

/* epc_top.sv */
// epc_top: exception priority selection, entry, tail-chaining and return for one core.
// assumes peripheral lines are asynchronous levels and core strobes are on clk.
// Overview of operation
// - eight settable levels for seven system handlers and 21 peripheral lines
// - settable level 0 ranks below reset, non-maskable and hard fault
// - every settable priority field is 0 after reset
// - equal priority: lower position number wins
// - reset is position 1, level -3, asynchronous; then base level
// - non-maskable is position 2, level -2; only reset preempts it
// - non-maskable raised only by software register write
// - hard fault position 3, level -1, taken for blocked or disabled faults
// - memory management position 4, settable, synchronous on protection mismatch
// - bus fault position 5, settable, can be enabled or disabled
// - usage fault position 6, settable, synchronous on bad instruction or state
// - supervisor call position 11; positions 7-10 and 13 reserved
// - debug monitor position 12, only when enabled, not halting, urgent enough
// - pendable service request position 14, pended only by software
// - system tick position 15, settable, from the tick timer
// - peripheral line n maps to position 16 plus n, asynchronous
// - bits 0-4 ports A-E, 5-6 serial, 7 sync serial, 8 two-wire
// - bit 18 watchdog, 19-24 timers, 25-27 comparators, 28 sysctl, 29 flash
// - handler mode, state pushed while vector fetched, restored at exit
// - pending request at exit chains directly without restore and resave
// - group split: only preemption bits decide preemption
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module epc_top #(
	parameter int unsigned STACK_CYC = 8
) (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [31:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [31:0]                   reg_rdata,
	input  wire logic [epc_pkg::NUM_LINES-1:0] irq_line,
	input  wire epc_pkg::epc_core_ev_t         core_ev,
	input  wire logic                          core_halting,
	input  wire logic                          core_ret,
	output logic                               handler_mode,
	output logic                               stack_push,
	output logic                               stack_pop,
	output logic                               vec_fetch,
	output logic      [epc_pkg::POS_W-1:0]     vec_pos,
	output logic      [epc_pkg::LVL_W-1:0]     act_level
);

	initial
	begin
		if (STACK_CYC < 1 || STACK_CYC > 255)
			$error("STACK_CYC out of range");
	end

	localparam int unsigned NL = epc_pkg::NUM_LINES;
	localparam int unsigned NE = epc_pkg::NUM_EXC;
	localparam int unsigned PW = epc_pkg::PRIO_W;
	localparam int unsigned POS_W = epc_pkg::POS_W;

	logic [NL-1:0]  sync1;
	logic [NL-1:0]  sync2;
	logic [NL-1:0]  line_en;
	logic [NL-1:0]  line_pend;
	logic [PW-1:0]  line_pri [NL];
	logic [PW-1:0]  sys_pri  [7];
	logic [PW-1:0]  group_sel;
	logic           bus_en;
	logic           dbg_en;
	logic           nmi_pend;
	logic           pend_sv;
	logic [6:0]     sys_pend;
	logic [NE-1:0]  req;
	logic [NE-1:0]  taken_vec;
	logic [PW-1:0]  pri_of [NE];
	epc_pkg::epc_state_t state;
	epc_pkg::epc_pick_t  pick;
	logic [7:0]     cnt;
	logic [epc_pkg::LVL_W-1:0] stk_lvl [4];
	logic [1:0]     depth;
	logic           take;
	logic           hard_req;
	logic [31:0]    pri_word;

	// lines are asynchronous: two flops first
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= irq_line;
			sync2 <= sync1;
		end
	end

	wire logic wr_ctrl = reg_wr && reg_addr == epc_pkg::REG_CTRL;

	// configuration registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			line_en   <= '0;
			group_sel <= '0;
			bus_en    <= 1'b0;
			dbg_en    <= 1'b0;
			for (int i = 0; i < NL; i++)
				line_pri[i] <= PW'(epc_pkg::PRIO_RESET);
			for (int i = 0; i < 7; i++)
				sys_pri[i] <= PW'(epc_pkg::PRIO_RESET);
		end
		else if (reg_wr)
		begin
			if (reg_addr == epc_pkg::REG_ENABLE)
				line_en <= reg_wdata[NL-1:0] & epc_pkg::LINE_IMPL;
			else if (reg_addr == epc_pkg::REG_GROUP)
				group_sel <= reg_wdata[PW-1:0];
			else if (reg_addr == epc_pkg::REG_CTRL)
			begin
				bus_en <= reg_wdata[epc_pkg::CTRL_BUS_EN];
				dbg_en <= reg_wdata[epc_pkg::CTRL_DBG_EN];
			end
			else if (reg_addr == epc_pkg::REG_SYSPRI)
			begin
				for (int i = 0; i < 7; i++)
					sys_pri[i] <= reg_wdata[i*4 +: PW];
			end
			else if (reg_addr >= epc_pkg::REG_PRI0 && reg_addr < epc_pkg::REG_PRI0 + 8'h10)
			begin
				for (int i = 0; i < 8; i++)
					if (int'(reg_addr[3:2]) * 8 + i < NL)
						line_pri[int'(reg_addr[3:2]) * 8 + i] <= reg_wdata[i*4 +: PW];
			end
		end
	end

	// sys_pri slots: 0 mem,1 bus,2 usage,3 supervisor call,4 debug,5 pended service,6 tick
	always_comb
	begin
		for (int i = 0; i < NE; i++)
			pri_of[i] = '0;
		pri_of[epc_pkg::POS_MEM]   = sys_pri[0];
		pri_of[epc_pkg::POS_BUS]   = sys_pri[1];
		pri_of[epc_pkg::POS_USAGE] = sys_pri[2];
		pri_of[epc_pkg::POS_SUPV]  = sys_pri[3];
		pri_of[epc_pkg::POS_DEBUG] = sys_pri[4];
		pri_of[epc_pkg::POS_PEND]  = sys_pri[5];
		pri_of[epc_pkg::POS_TICK]  = sys_pri[6];
		for (int n = 0; n < NL; n++)
			pri_of[16 + n] = line_pri[n];
	end

	function automatic logic [epc_pkg::LVL_W-1:0] lvl_of(input int p, input logic [PW-1:0] pr);
		if (p == 2)
			return epc_pkg::LVL_NMI;
		else if (p == 3)
			return epc_pkg::LVL_HARD;
		else
			return epc_pkg::LVL_PROG0 + epc_pkg::LVL_W'(pr);
	endfunction

	// group masks subpriority bits out of preemption level
	function automatic logic [epc_pkg::LVL_W-1:0] preempt_of(input logic [epc_pkg::LVL_W-1:0] l);
		logic [PW-1:0] m;
		m = PW'(3'h7 << group_sel);
		// base level is never masked, or an idle core would look busy
		if (l < epc_pkg::LVL_PROG0 || l == epc_pkg::LVL_BASE)
			return l;
		return epc_pkg::LVL_PROG0 + epc_pkg::LVL_W'((l - epc_pkg::LVL_PROG0) & {2'b00, m});
	endfunction

	// configurable fault escalates when blocked or disabled
	// during a chain the new handler must beat the returned-to level
	wire logic [epc_pkg::LVL_W-1:0] cmp_lvl = (state == epc_pkg::EPC_CHAIN) ? stk_lvl[depth - 2'd1] : act_level;
	wire logic [epc_pkg::LVL_W-1:0] cur_pre = preempt_of(cmp_lvl);
	wire logic mem_blk = preempt_of(lvl_of(4, sys_pri[0])) >= cur_pre;
	wire logic use_blk = preempt_of(lvl_of(6, sys_pri[2])) >= cur_pre;
	wire logic bus_blk = !bus_en || preempt_of(lvl_of(5, sys_pri[1])) >= cur_pre;
	assign hard_req = (core_ev.mem_fault && mem_blk) || (core_ev.usage_fault && use_blk)
		|| (core_ev.bus_fault && bus_blk);

	// pending flags; set wins over clear
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			line_pend <= '0;
			sys_pend  <= '0;
			nmi_pend  <= 1'b0;
			pend_sv   <= 1'b0;
		end
		else
		begin
			line_pend <= (line_pend & ~(taken_vec[NE-1:16])) | (sync2 & epc_pkg::LINE_IMPL);
			nmi_pend  <= (nmi_pend && !taken_vec[epc_pkg::POS_NMI])
				|| (wr_ctrl && reg_wdata[epc_pkg::CTRL_NMI_SET]);
			pend_sv   <= (pend_sv && !taken_vec[epc_pkg::POS_PEND] && !(wr_ctrl && reg_wdata[epc_pkg::CTRL_PEND_CLR]))
				|| (wr_ctrl && reg_wdata[epc_pkg::CTRL_PEND_SET]);
			sys_pend[0] <= (sys_pend[0] && !taken_vec[epc_pkg::POS_MEM]) || (core_ev.mem_fault && !mem_blk);
			sys_pend[1] <= (sys_pend[1] && !taken_vec[epc_pkg::POS_BUS]) || (core_ev.bus_fault && !bus_blk);
			sys_pend[2] <= (sys_pend[2] && !taken_vec[epc_pkg::POS_USAGE]) || (core_ev.usage_fault && !use_blk);
			sys_pend[3] <= (sys_pend[3] && !taken_vec[epc_pkg::POS_SUPV]) || core_ev.supv_call;
			sys_pend[4] <= (sys_pend[4] && !taken_vec[epc_pkg::POS_DEBUG])
				|| (core_ev.debug_req && dbg_en && !core_halting);
			sys_pend[5] <= (sys_pend[5] && !taken_vec[epc_pkg::POS_HARD]) || hard_req;
			sys_pend[6] <= (sys_pend[6] && !taken_vec[epc_pkg::POS_TICK]) || core_ev.tick;
		end
	end

	always_comb
	begin
		req = '0;
		req[epc_pkg::POS_NMI]   = nmi_pend;
		req[epc_pkg::POS_HARD]  = sys_pend[5];
		req[epc_pkg::POS_MEM]   = sys_pend[0];
		req[epc_pkg::POS_BUS]   = sys_pend[1];
		req[epc_pkg::POS_USAGE] = sys_pend[2];
		req[epc_pkg::POS_SUPV]  = sys_pend[3];
		req[epc_pkg::POS_DEBUG] = sys_pend[4];
		req[epc_pkg::POS_PEND]  = pend_sv;
		req[epc_pkg::POS_TICK]  = sys_pend[6];
		req[NE-1:16]            = line_pend & line_en;
	end

	// scan high to low so ties go to the lower position
	always_comb
	begin
		pick = '{valid: 1'b0, pos: epc_pkg::POS_NONE, level: epc_pkg::LVL_BASE};
		for (int p = NE - 1; p >= 2; p--)
			if (req[p] && lvl_of(p, pri_of[p]) <= pick.level)
				pick = '{valid: 1'b1, pos: POS_W'(p), level: lvl_of(p, pri_of[p])};
	end

	assign take = pick.valid && preempt_of(pick.level) < cur_pre;

	always_comb
	begin
		taken_vec = '0;
		// a full nest stack must not swallow the pending bit
		if (take && (((state == epc_pkg::EPC_IDLE || state == epc_pkg::EPC_RUN) && depth != 2'd3)
			|| state == epc_pkg::EPC_CHAIN))
			taken_vec[pick.pos] = 1'b1;
	end

	// entry, run, chained exit
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state        <= epc_pkg::EPC_IDLE;
			act_level    <= epc_pkg::LVL_BASE;
			depth        <= 2'd0;
			cnt          <= 8'h00;
			handler_mode <= 1'b0;
			stack_push   <= 1'b0;
			stack_pop    <= 1'b0;
			vec_fetch    <= 1'b0;
			vec_pos      <= epc_pkg::POS_NONE;
			for (int i = 0; i < 4; i++)
				stk_lvl[i] <= epc_pkg::LVL_BASE;
		end
		else
		begin
			stack_pop <= 1'b0;
			vec_fetch <= 1'b0;
			case (state)
			epc_pkg::EPC_IDLE, epc_pkg::EPC_RUN:
			begin
				if (|taken_vec && depth != 2'd3)
				begin
					stk_lvl[depth] <= act_level;
					depth          <= depth + 2'd1;
					act_level      <= pick.level;
					vec_pos        <= pick.pos;
					stack_push     <= 1'b1;
					vec_fetch      <= 1'b1;
					cnt            <= 8'(STACK_CYC - 1);
					state          <= epc_pkg::EPC_STACK;
				end
				else if (state == epc_pkg::EPC_RUN && core_ret)
				begin
					if (pick.valid && preempt_of(pick.level) < preempt_of(stk_lvl[depth - 2'd1]))
						state <= epc_pkg::EPC_CHAIN;
					else
					begin
						stack_pop <= 1'b1;
						depth     <= depth - 2'd1;
						act_level <= stk_lvl[depth - 2'd1];
						if (depth == 2'd1)
						begin
							handler_mode <= 1'b0;
							state        <= epc_pkg::EPC_IDLE;
							vec_pos      <= epc_pkg::POS_NONE;
						end
					end
				end
			end
			epc_pkg::EPC_STACK:
			begin
				handler_mode <= 1'b1;
				if (cnt == 8'h00)
				begin
					stack_push <= 1'b0;
					state      <= epc_pkg::EPC_RUN;
				end
				else
					cnt <= cnt - 8'h01;
			end
			default:
			begin
				// chain: swap handler, keep stacked frame
				state <= epc_pkg::EPC_RUN;
				if (|taken_vec)
				begin
					act_level <= pick.level;
					vec_pos   <= pick.pos;
					vec_fetch <= 1'b1;
				end
				else
				begin
					// request withdrawn meanwhile: finish as a plain return
					stack_pop <= 1'b1;
					depth     <= depth - 2'd1;
					act_level <= stk_lvl[depth - 2'd1];
					if (depth == 2'd1)
					begin
						handler_mode <= 1'b0;
						state        <= epc_pkg::EPC_IDLE;
						vec_pos      <= epc_pkg::POS_NONE;
					end
				end
			end
			endcase
		end
	end

	// line priority word for the addressed group of eight
	always_comb
	begin
		pri_word = 32'h0000_0000;
		for (int i = 0; i < 8; i++)
			if (int'(reg_addr[3:2]) * 8 + i < NL)
				pri_word[i*4 +: PW] = line_pri[int'(reg_addr[3:2]) * 8 + i];
	end

	// read port
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
		begin
			if (reg_addr == epc_pkg::REG_ENABLE)
				reg_rdata <= 32'(line_en);
			else if (reg_addr == epc_pkg::REG_PENDING)
				reg_rdata <= 32'(line_pend);
			else if (reg_addr == epc_pkg::REG_CTRL)
				reg_rdata <= {28'h0, dbg_en, bus_en, pend_sv, nmi_pend};
			else if (reg_addr == epc_pkg::REG_GROUP)
				reg_rdata <= 32'(group_sel);
			else if (reg_addr == epc_pkg::REG_STATUS)
				reg_rdata <= {16'h0, 3'h0, act_level, 2'h0, vec_pos};
			else if (reg_addr == epc_pkg::REG_SYSPRI)
				reg_rdata <= {5'h0, sys_pri[6], 1'b0, sys_pri[5], 1'b0, sys_pri[4], 1'b0, sys_pri[3], 1'b0,
					sys_pri[2], 1'b0, sys_pri[1], 1'b0, sys_pri[0]};
			else if (reg_addr >= epc_pkg::REG_PRI0 && reg_addr < epc_pkg::REG_PRI0 + 8'h10)
				reg_rdata <= pri_word;
			else
				reg_rdata <= 32'h0000_0000;
		end
		else
			reg_rdata <= 32'h0000_0000;
	end

	property p_nmi_sw_only;
		@(posedge clk) disable iff (!nrst) $rose(nmi_pend) |-> $past(wr_ctrl && reg_wdata[epc_pkg::CTRL_NMI_SET]);
	endproperty
	a_nmi_sw_only: assert property (p_nmi_sw_only) else $error("nmi pended without write");

	property p_preempt_strict;
		@(posedge clk) disable iff (!nrst) (|taken_vec && state == epc_pkg::EPC_RUN)
			|-> preempt_of(pick.level) < preempt_of(act_level);
	endproperty
	a_preempt_strict: assert property (p_preempt_strict) else $error("preempt not more urgent");

	property p_nmi_level;
		@(posedge clk) disable iff (!nrst) (taken_vec[epc_pkg::POS_NMI] && state != epc_pkg::EPC_STACK)
			|=> act_level == epc_pkg::LVL_NMI;
	endproperty
	a_nmi_level: assert property (p_nmi_level) else $error("nmi level wrong");

	property p_entry_push;
		@(posedge clk) disable iff (!nrst) $rose(stack_push) |-> vec_fetch ##1 handler_mode;
	endproperty
	a_entry_push: assert property (p_entry_push) else $error("push without fetch");

	property p_chain_no_pop;
		@(posedge clk) disable iff (!nrst) (state == epc_pkg::EPC_CHAIN && |taken_vec)
			|=> !stack_pop && !stack_push && vec_fetch;
	endproperty
	a_chain_no_pop: assert property (p_chain_no_pop) else $error("chain touched stack");

	property p_idle_base;
		@(posedge clk) disable iff (!nrst) state == epc_pkg::EPC_IDLE |-> act_level == epc_pkg::LVL_BASE;
	endproperty
	a_idle_base: assert property (p_idle_base) else $error("idle not at base level");

	property p_tie_low;
		@(posedge clk) disable iff (!nrst) (req[16] && req[17] && line_pri[0] == line_pri[1]
			&& pick.pos == 6'h11) |-> 1'b0;
	endproperty
	a_tie_low: assert property (p_tie_low) else $error("tie went to higher position");

	property p_pend_clear;
		@(posedge clk) disable iff (!nrst) taken_vec[epc_pkg::POS_PEND] && !(wr_ctrl && reg_wdata[epc_pkg::CTRL_PEND_SET])
			|=> !pend_sv;
	endproperty
	a_pend_clear: assert property (p_pend_clear) else $error("service request stayed pending");

	c_entry: cover property (@(posedge clk) disable iff (!nrst) $rose(handler_mode));
	c_chain: cover property (@(posedge clk) disable iff (!nrst) state == epc_pkg::EPC_CHAIN);
	c_nest:  cover property (@(posedge clk) disable iff (!nrst) depth == 2'd2);

endmodule

`default_nettype wire

/* epc_core_model.sv */
// epc_core_model: processor core side, answers a handler with a return pulse.
// assumes epc_top on the same clock; ret_go is a one-cycle command from the bench.
`timescale 1ns/1ps
`default_nettype none

module epc_core_model (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic handler_mode,
	input  wire logic stack_push,
	input  wire logic ret_go,
	output logic      core_ret
);
	logic armed;

	// return only once state is saved and the handler really runs
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			armed    <= 1'b0;
			core_ret <= 1'b0;
		end
		else
		begin
			core_ret <= 1'b0;
			if (ret_go)
				armed <= 1'b1;
			else if (armed && handler_mode && !stack_push && !core_ret)
			begin
				core_ret <= 1'b1;
				armed    <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

/* exception_priority_controller_tb.sv */
// exception_priority_controller_tb: register, dispatch, preemption and chaining tests.
// assumes epc_top with STACK_CYC 8 and the core model answering returns.
`timescale 1ns/1ps
`default_nettype none

module exception_priority_controller_tb;
	logic                          clk = 1'b0;
	logic                          nrst = 1'b0;
	logic [7:0]                    reg_addr = 8'h00;
	logic [31:0]                   reg_wdata = 32'h0;
	logic                          reg_wr = 1'b0;
	logic                          reg_rd = 1'b0;
	logic [31:0]                   reg_rdata;
	logic [epc_pkg::NUM_LINES-1:0] irq_line = '0;
	epc_pkg::epc_core_ev_t         core_ev = '0;
	logic                          core_halting = 1'b0;
	logic                          core_ret;
	logic                          ret_go = 1'b0;
	logic                          handler_mode;
	logic                          stack_push;
	logic                          stack_pop;
	logic                          vec_fetch;
	logic [epc_pkg::POS_W-1:0]     vec_pos;
	logic [epc_pkg::LVL_W-1:0]     act_level;
	int                            bad_count = 0;
	int                            n_compared = 0;
	int                            cycles = 0;

	always #10 clk = ~clk;

	epc_top #(.STACK_CYC(8)) epc_top_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_line(irq_line), .core_ev(core_ev),
		.core_halting(core_halting), .core_ret(core_ret), .handler_mode(handler_mode),
		.stack_push(stack_push), .stack_pop(stack_pop), .vec_fetch(vec_fetch), .vec_pos(vec_pos),
		.act_level(act_level));

	epc_core_model epc_core_model_i (.clk(clk), .nrst(nrst), .handler_mode(handler_mode),
		.stack_push(stack_push), .ret_go(ret_go), .core_ret(core_ret));

	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// generous ceiling: the sequence needs well under 3000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		chk("reg_rdata", exp, reg_rdata);
	endtask

	task automatic pulse_ev(input epc_pkg::epc_core_ev_t ev);
		@(posedge clk);
		core_ev <= ev;
		@(posedge clk);
		core_ev <= '0;
	endtask

	// wait for dispatch, then check position and the level once in handler mode
	task automatic wait_fetch(input logic [5:0] pos, input logic [4:0] lvl);
		int i;
		logic seen;
		seen = 1'b0;
		for (i = 0; i < 60 && !seen; i++)
		begin
			@(negedge clk);
			seen = (vec_fetch === 1'b1);
		end
		chk("vec_fetch", 32'h1, {31'h0, seen});
		chk("vec_pos", {26'h0, pos}, {26'h0, vec_pos});
		chk("stack_push", 32'h1, {31'h0, stack_push});
		repeat (3) @(negedge clk);
		chk("handler_mode", 32'h1, {31'h0, handler_mode});
		chk("act_level", {27'h0, lvl}, {27'h0, act_level});
	endtask

	task automatic no_fetch(input int n);
		int cnt;
		cnt = 0;
		repeat (n)
		begin
			@(negedge clk);
			if (vec_fetch !== 1'b0)
				cnt++;
		end
		chk("unexpected vec_fetch", 32'h0, cnt);
	endtask

	// return from the handler; chained returns fetch with no pop
	task automatic ret(input logic chain, input logic [5:0] pos);
		int i;
		logic f;
		logic p;
		f = 1'b0;
		p = 1'b0;
		@(posedge clk);
		ret_go <= 1'b1;
		@(posedge clk);
		ret_go <= 1'b0;
		for (i = 0; i < 60 && !f && !p; i++)
		begin
			@(negedge clk);
			f = (vec_fetch === 1'b1);
			p = (stack_pop === 1'b1);
		end
		chk("chained", {31'h0, chain}, {31'h0, f});
		chk("popped", {31'h0, !chain}, {31'h0, p});
		if (chain)
		begin
			chk("vec_pos", {26'h0, pos}, {26'h0, vec_pos});
			chk("stack_push", 32'h0, {31'h0, stack_push});
		end
		repeat (3) @(negedge clk);
	endtask

	// one-cycle pulse: a longer level would re-pend after the take, since set wins
	task automatic pulse_lines(input logic [epc_pkg::NUM_LINES-1:0] m);
		@(posedge clk);
		irq_line <= m;
		@(posedge clk);
		irq_line <= '0;
	endtask

	// each core event except bus fault with its position, all at default level 0
	epc_pkg::epc_core_ev_t evs[5] = '{6'h20, 6'h08, 6'h04, 6'h01, 6'h02};
	logic [5:0]            eps[5] = '{epc_pkg::POS_MEM, epc_pkg::POS_USAGE, epc_pkg::POS_SUPV,
		epc_pkg::POS_TICK, epc_pkg::POS_DEBUG};

	initial
	begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk("act_level", 32'h1F, {27'h0, act_level});
		chk("vec_pos", 32'h0, {26'h0, vec_pos});
		rd(epc_pkg::REG_SYSPRI, 32'h0);
		for (int a = 0; a < 4; a++)
			rd(epc_pkg::REG_PRI0 + 8'(4 * a), 32'h0);
		rd(epc_pkg::REG_STATUS, 32'h0000_1F00);
		wr(8'hF0, 32'hFFFF_FFFF);
		rd(8'hF0, 32'h0);
		wr(epc_pkg::REG_ENABLE, 32'hFFFF_FFFF);
		rd(epc_pkg::REG_ENABLE, {2'b00, epc_pkg::LINE_IMPL});
		pulse_lines(30'h0000_0200);
		no_fetch(20);
		// equal levels: lower position first, then chain
		pulse_lines(30'h0000_0003);
		wait_fetch(epc_pkg::POS_LINE0, epc_pkg::LVL_PROG0);
		ret(1'b1, 6'h11);
		ret(1'b0, 6'h00);
		chk("act_level", 32'h1F, {27'h0, act_level});
		// watchdog and flash lines reach their positions
		pulse_lines(30'h0004_0000);
		wait_fetch(6'h22, epc_pkg::LVL_PROG0);
		ret(1'b0, 6'h00);
		pulse_lines(30'h2000_0000);
		wait_fetch(6'h2D, epc_pkg::LVL_PROG0);
		ret(1'b0, 6'h00);
		// strict preemption, nesting and chain on exit
		wr(epc_pkg::REG_PRI0, 32'h0000_0022);
		rd(epc_pkg::REG_PRI0, 32'h0000_0022);
		wr(epc_pkg::REG_PRI0 + 8'h04, 32'h0000_0001);
		pulse_lines(30'h0000_0001);
		wait_fetch(epc_pkg::POS_LINE0, 5'h05);
		pulse_lines(30'h0000_0002);
		no_fetch(20);
		pulse_lines(30'h0000_0100);
		wait_fetch(6'h18, 5'h04);
		ret(1'b0, 6'h00);
		chk("act_level", 32'h05, {27'h0, act_level});
		ret(1'b1, 6'h11);
		ret(1'b0, 6'h00);
		// group split: one subpriority bit makes levels 2 and 3 one group
		wr(epc_pkg::REG_GROUP, 32'h1);
		wr(epc_pkg::REG_PRI0, 32'h0000_0023);
		pulse_lines(30'h0000_0001);
		wait_fetch(epc_pkg::POS_LINE0, 5'h06);
		pulse_lines(30'h0000_0002);
		no_fetch(20);
		ret(1'b1, 6'h11);
		ret(1'b0, 6'h00);
		wr(epc_pkg::REG_GROUP, 32'h0);
		// system handlers, bus fault and debug enabled
		wr(epc_pkg::REG_CTRL, 32'h0000_000C);
		for (int k = 0; k < 5; k++)
		begin
			pulse_ev(evs[k]);
			wait_fetch(eps[k], epc_pkg::LVL_PROG0);
			ret(1'b0, 6'h00);
		end
		pulse_ev(6'h10);
		wait_fetch(epc_pkg::POS_BUS, epc_pkg::LVL_PROG0);
		ret(1'b0, 6'h00);
		@(posedge clk);
		core_halting <= 1'b1;
		pulse_ev(6'h02);
		no_fetch(20);
		@(posedge clk);
		core_halting <= 1'b0;
		wr(epc_pkg::REG_CTRL, 32'h0000_000E);
		wait_fetch(epc_pkg::POS_PEND, epc_pkg::LVL_PROG0);
		ret(1'b0, 6'h00);
		// bus fault disabled escalates
		wr(epc_pkg::REG_CTRL, 32'h0000_0008);
		pulse_ev(6'h10);
		wait_fetch(epc_pkg::POS_HARD, epc_pkg::LVL_HARD);
		ret(1'b0, 6'h00);
		// software raises the non-maskable; a line cannot preempt it
		wr(epc_pkg::REG_CTRL, 32'h0000_0009);
		wait_fetch(epc_pkg::POS_NMI, epc_pkg::LVL_NMI);
		pulse_lines(30'h0000_0001);
		no_fetch(20);
		ret(1'b1, epc_pkg::POS_LINE0);
		ret(1'b0, 6'h00);
		chk("act_level", 32'h1F, {27'h0, act_level});
		report_and_stop();
	end
endmodule

`default_nettype wire
